// file: include/ire_pkg.sv
// constants, carriers and state codes of the instrument reset-effects sequencer
// assumes a 32-bit classic wishbone master and one core clock of 10 MHz
package ire_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus carrier
    localparam int ADR_W = 9;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [8:0] adr;
        logic [31:0] dat;
    } ire_wb_req_type;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [8:0] OFS_STATUS = 9'h000;
    localparam logic [8:0] OFS_MODE = 9'h008;
    localparam logic [8:0] OFS_OPC = 9'h00c;
    localparam logic [8:0] OFS_SRQ = 9'h010;
    localparam logic [8:0] OFS_CFG = 9'h014;
    localparam logic [8:0] OFS_TITLE = 9'h018;
    localparam logic [8:0] OFS_MENU = 9'h01c;
    localparam logic [8:0] OFS_MEM_BASE = 9'h100;

    ////////////////////////////////////////////////////////////////////////////////
    // status-structure word store: enables, then negative, then positive filters
    localparam int MEM_AW = 5;
    localparam int MEM_DW = 16;
    localparam logic [4:0] NTR_BASE = 5'h09;
    localparam logic [4:0] PTR_BASE = 5'h10;
    localparam logic [4:0] MEM_LAST = 5'h16;
    localparam logic [15:0] ENABLE_INIT = 16'h0000;
    localparam logic [15:0] NTR_INIT = 16'h0000;
    localparam logic [15:0] PTR_INIT = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions and defaults
    localparam int MODE_TRIG_BIT = 0;
    localparam int MODE_RETRIG_BIT = 1;
    localparam int MODE_LOCK_BIT = 2;
    localparam int MODE_SCREEN_LSB = 4;
    localparam int SCREEN_W = 4;
    localparam logic [3:0] SCREEN_RX_TEST = 4'h1;

    localparam int OPC_CMD_BIT = 0;
    localparam int OPC_QUERY_BIT = 1;
    localparam int OPC_OP_BIT = 2;
    localparam int OPC_EVENT_BIT = 3;
    localparam int OPC_REPLY_BIT = 4;

    localparam int SRQ_SET_BIT = 0;
    localparam int SRQ_CLR_BIT = 1;

    localparam logic [15:0] CFG_RESTORE_MASK = 16'h0fff;
    localparam logic [15:0] CFG_DEFAULT = 16'h0005;
    localparam logic [31:0] TITLE_CLEARED = 32'h0000_0000;
    localparam logic [31:0] MENU_INIT = 32'h0000_0000;

    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TEST_RAN_BIT = 1;
    localparam int ST_POR_BIT = 2;
    localparam int ST_PRESET_BIT = 3;
    localparam int ST_TEST_PASS_BIT = 4;
    localparam int ST_STATE_LSB = 8;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_INIT = 2'b01,
        SEQ_TEST = 2'b10,
        SEQ_DONE = 2'b11
    } ire_seq_type;

endpackage

// file: rtl/ire_stat_mem.sv
// word store for the status-structure enable and transition filter registers
// assumes one writer per cycle; read data are registered, one cycle behind addr
`timescale 1ns/1ps
module ire_stat_mem (
    input wire logic core_clk,
    input wire logic [4:0] addr,
    input wire logic [1:0] wr_be,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data_q
);
    logic [15:0] mem_q [0:31];

    // no reset: contents are only defined once the power-on walk has run
    always_ff @(posedge core_clk) begin
        if (wr_be[0]) begin
            mem_q[addr][7:0] <= wr_data[7:0];
        end
        if (wr_be[1]) begin
            mem_q[addr][15:8] <= wr_data[15:8];
        end
        rd_data_q <= mem_q[addr];
    end
endmodule

// file: rtl/ire_top.sv
// reset-effects sequencer: power-on and preset reset, wishbone register slave
// assumes synchronous inputs; self-test engine and bus interface sit outside
//
// Functional notes
// - power-up or key press starts its reset
// - power-on reset runs self-test diagnostics
// - preset reset never starts self-test
// - power-on clears all nine enable masks
// - power-on loads negative filters with zeros
// - power-on loads positive filters with ones
// - power-on resets bus interface, drops request
// - preset leaves bus interface and request
// - preset keeps every enable mask
// - preset keeps every negative filter
// - preset keeps every positive filter
// - either reset aborts pending operations
// - either reset forgets completion command
// - either reset forgets completion query reply
// - either reset sets full settling, repetitive
// - either reset unlocks display, shows receiver
// - stored setups untouched by either reset
// - calibration data untouched by either reset
// - memory contents untouched by either reset
// - only listed config fields restored
// - main menu, external setups kept
// - either reset clears print title
`timescale 1ns/1ps
module ire_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire ire_pkg::ire_wb_req_type wb_req,
    output logic wb_ack,
    output logic [31:0] wb_dat_o,
    input wire logic power_ok,
    input wire logic preset_key,
    output logic selftest_start,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    input wire logic op_done,
    output logic abort_ops,
    output logic bus_if_reset,
    output logic srq,
    output logic full_settling_trigger,
    output logic repetitive_retrigger,
    output logic display_locked,
    output logic [3:0] screen_sel,
    output logic [15:0] cfg_fields,
    output logic [31:0] print_title,
    output logic reset_busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] init_value(input logic [4:0] idx);
        if (idx >= ire_pkg::PTR_BASE) begin
            return ire_pkg::PTR_INIT;
        end else if (idx >= ire_pkg::NTR_BASE) begin
            return ire_pkg::NTR_INIT;
        end
        return ire_pkg::ENABLE_INIT;
    endfunction

    function automatic logic mem_hit(input logic [8:0] adr);
        return (adr[8:7] == ire_pkg::OFS_MEM_BASE[8:7]) && (adr[6:2] <= ire_pkg::MEM_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    ire_pkg::ire_seq_type seq_q;
    ire_pkg::ire_seq_type seq_d;
    logic [4:0] idx_q;
    logic por_arm_q;
    logic power_ok_q;
    logic key_q;
    logic test_ran_q;
    logic test_pass_q;
    logic cause_por_q;
    logic cause_preset_q;
    logic selftest_start_q;
    logic abort_q;
    logic bus_if_reset_q;

    logic pend_q;
    logic ack_q;
    logic we_q;
    logic [3:0] sel_q;
    logic [8:0] adr_q;
    logic [31:0] wdat_q;
    logic mem_sel_q;
    logic [31:0] dat_q;

    logic [31:0] mode_q;
    logic [31:0] cfg_q;
    logic [31:0] title_q;
    logic [31:0] menu_q;
    logic srq_q;
    logic opc_cmd_q;
    logic opc_query_q;
    logic op_pend_q;
    logic opc_event_q;
    logic opc_reply_q;

    logic [15:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // reset triggers

    wire power_rise = power_ok && !power_ok_q;
    wire key_rise = preset_key && !key_q;
    // a power event restarts the walk from any state; power outranks the key
    wire por_go = por_arm_q || power_rise;
    wire seq_idle = (seq_q == ire_pkg::SEQ_IDLE);
    wire preset_go = key_rise && seq_idle && !por_go;
    wire any_go = por_go || preset_go;
    wire busy = !seq_idle;

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            ire_pkg::SEQ_IDLE: begin
                seq_d = ire_pkg::SEQ_IDLE;
            end
            ire_pkg::SEQ_INIT: begin
                if (idx_q == ire_pkg::MEM_LAST) begin
                    seq_d = ire_pkg::SEQ_TEST;
                end
            end
            ire_pkg::SEQ_TEST: begin
                if (selftest_done) begin
                    seq_d = ire_pkg::SEQ_DONE;
                end
            end
            ire_pkg::SEQ_DONE: begin
                seq_d = ire_pkg::SEQ_IDLE;
            end
            default: begin
                seq_d = ire_pkg::SEQ_IDLE;
            end
        endcase
        // only the power-on path enters the walk and the self-test
        if (por_go) begin
            seq_d = ire_pkg::SEQ_INIT;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_q <= ire_pkg::SEQ_IDLE;
            idx_q <= 5'h00;
            por_arm_q <= 1'b1;
            power_ok_q <= 1'b0;
            key_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            por_arm_q <= 1'b0;
            power_ok_q <= power_ok;
            key_q <= preset_key;
            if (por_go) begin
                idx_q <= 5'h00;
            end else if (seq_q == ire_pkg::SEQ_INIT) begin
                idx_q <= idx_q + 5'h01;
            end
        end
    end

    // self-test handshake only from the power-on walk; preset never reaches it
    wire test_kick = (seq_q == ire_pkg::SEQ_INIT) && (idx_q == ire_pkg::MEM_LAST) && !por_go;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            selftest_start_q <= 1'b0;
            test_ran_q <= 1'b0;
            test_pass_q <= 1'b0;
            cause_por_q <= 1'b0;
            cause_preset_q <= 1'b0;
            abort_q <= 1'b0;
            bus_if_reset_q <= 1'b0;
        end else begin
            selftest_start_q <= test_kick;
            abort_q <= any_go;
            bus_if_reset_q <= por_go;
            if (por_go) begin
                cause_por_q <= 1'b1;
                cause_preset_q <= 1'b0;
                test_ran_q <= 1'b0;
            end else if (preset_go) begin
                cause_por_q <= 1'b0;
                cause_preset_q <= 1'b1;
            end
            if (seq_q == ire_pkg::SEQ_TEST && selftest_done && !por_go) begin
                test_ran_q <= 1'b1;
                test_pass_q <= selftest_pass;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone slave: accept, one pending cycle for commit and read, then ack

    wire accept = wb_req.cyc && wb_req.stb && !ack_q && !pend_q && !busy;
    wire wr_commit = pend_q && we_q;
    wire wr_mem = wr_commit && mem_sel_q;
    wire hit_mode = (adr_q == ire_pkg::OFS_MODE);
    wire hit_opc = (adr_q == ire_pkg::OFS_OPC);
    wire hit_srq = (adr_q == ire_pkg::OFS_SRQ);
    wire hit_cfg = (adr_q == ire_pkg::OFS_CFG);
    wire hit_title = (adr_q == ire_pkg::OFS_TITLE);
    wire hit_menu = (adr_q == ire_pkg::OFS_MENU);
    wire [31:0] wr_eff = wb_merge(32'h0000_0000, wdat_q, sel_q);
    wire [31:0] mode_wr = wb_merge(mode_q, wdat_q, sel_q);
    wire [31:0] cfg_wr = wb_merge(cfg_q, wdat_q, sel_q);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
            we_q <= 1'b0;
            sel_q <= 4'h0;
            adr_q <= 9'h000;
            wdat_q <= 32'h0000_0000;
            mem_sel_q <= 1'b0;
        end else begin
            pend_q <= accept;
            ack_q <= pend_q;
            if (accept) begin
                we_q <= wb_req.we;
                sel_q <= wb_req.sel;
                adr_q <= {wb_req.adr[8:2], 2'b00};
                wdat_q <= wb_req.dat;
                mem_sel_q <= mem_hit(wb_req.adr);
            end
        end
    end

    // the walk owns the store; the bus cannot reach it until the walk is over
    wire walk = (seq_q == ire_pkg::SEQ_INIT);
    wire [4:0] mem_addr = walk ? idx_q : (pend_q ? adr_q[6:2] : wb_req.adr[6:2]);
    wire [1:0] mem_be = walk ? 2'b11 : (wr_mem ? sel_q[1:0] : 2'b00);
    wire [15:0] mem_wdata = walk ? init_value(idx_q) : wdat_q[15:0];

    ire_stat_mem u_stat_mem (
        .core_clk(core_clk),
        .addr(mem_addr),
        .wr_be(mem_be),
        .wr_data(mem_wdata),
        .rd_data_q(mem_rdata)
    );

    wire [31:0] status_word = {22'h0, seq_q, 3'h0, test_pass_q, cause_preset_q, cause_por_q,
                               test_ran_q, busy};
    wire [31:0] opc_word = {27'h0, opc_reply_q, opc_event_q, op_pend_q, opc_query_q, opc_cmd_q};
    wire [31:0] reg_rd = (adr_q == ire_pkg::OFS_STATUS) ? status_word :
                         hit_mode ? mode_q :
                         hit_opc ? opc_word :
                         hit_srq ? {31'h0, srq_q} :
                         hit_cfg ? cfg_q :
                         hit_title ? title_q :
                         hit_menu ? menu_q : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dat_q <= 32'h0000_0000;
        end else if (pend_q) begin
            dat_q <= mem_sel_q ? {16'h0000, mem_rdata} : reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operating state touched by both resets

    wire [31:0] mode_dflt = {24'h0, ire_pkg::SCREEN_RX_TEST, 4'b0011};
    wire [31:0] cfg_dflt = {16'h0000, (cfg_q[15:0] & ~ire_pkg::CFG_RESTORE_MASK) |
                            (ire_pkg::CFG_DEFAULT & ire_pkg::CFG_RESTORE_MASK)};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= mode_dflt;
            cfg_q <= {16'h0000, ire_pkg::CFG_DEFAULT};
            title_q <= ire_pkg::TITLE_CLEARED;
            menu_q <= ire_pkg::MENU_INIT;
        end else begin
            if (any_go) begin
                mode_q <= mode_dflt;
                cfg_q <= cfg_dflt;
                title_q <= ire_pkg::TITLE_CLEARED;
            end else if (wr_commit) begin
                if (hit_mode) begin
                    mode_q <= {24'h0, mode_wr[7:4], 1'b0, mode_wr[2:0]};
                end
                if (hit_cfg) begin
                    cfg_q <= {16'h0000, cfg_wr[15:0]};
                end
                if (hit_title) begin
                    title_q <= wb_merge(title_q, wdat_q, sel_q);
                end
            end
            // menu and external-device setup is never touched by a reset
            if (wr_commit && hit_menu) begin
                menu_q <= wb_merge(menu_q, wdat_q, sel_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // service request and operation-complete tracking

    wire srq_set = wr_commit && hit_srq && wr_eff[ire_pkg::SRQ_SET_BIT];
    wire srq_clr = wr_commit && hit_srq && wr_eff[ire_pkg::SRQ_CLR_BIT];
    wire opc_wr = wr_commit && hit_opc;
    wire complete = op_pend_q && op_done;
    wire ev_set = complete && opc_cmd_q;
    wire reply_set = complete && opc_query_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            srq_q <= 1'b0;
        end else if (por_go) begin
            srq_q <= 1'b0;
        end else if (srq_set) begin
            srq_q <= 1'b1;
        end else if (srq_clr) begin
            srq_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            opc_cmd_q <= 1'b0;
            opc_query_q <= 1'b0;
            op_pend_q <= 1'b0;
            opc_event_q <= 1'b0;
            opc_reply_q <= 1'b0;
        end else begin
            if (any_go) begin
                op_pend_q <= 1'b0;
                opc_cmd_q <= 1'b0;
                opc_query_q <= 1'b0;
                opc_reply_q <= 1'b0;
            end else begin
                if (opc_wr && wr_eff[ire_pkg::OPC_OP_BIT]) begin
                    op_pend_q <= 1'b1;
                end else if (op_done) begin
                    op_pend_q <= 1'b0;
                end
                if (opc_wr && wr_eff[ire_pkg::OPC_CMD_BIT]) begin
                    opc_cmd_q <= 1'b1;
                end else if (complete) begin
                    opc_cmd_q <= 1'b0;
                end
                if (opc_wr && wr_eff[ire_pkg::OPC_QUERY_BIT]) begin
                    opc_query_q <= 1'b1;
                end else if (complete) begin
                    opc_query_q <= 1'b0;
                end
                // set beats the write-one clear in the same cycle
                if (reply_set) begin
                    opc_reply_q <= 1'b1;
                end else if (opc_wr && wr_eff[ire_pkg::OPC_REPLY_BIT]) begin
                    opc_reply_q <= 1'b0;
                end
            end
            if (ev_set) begin
                opc_event_q <= 1'b1;
            end else if (opc_wr && wr_eff[ire_pkg::OPC_EVENT_BIT]) begin
                opc_event_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; setups, calibration and bulk memory live elsewhere and get no
    // clear strobe from this block at all

    assign wb_ack = ack_q;
    assign wb_dat_o = dat_q;
    assign selftest_start = selftest_start_q;
    assign abort_ops = abort_q;
    assign bus_if_reset = bus_if_reset_q;
    assign srq = srq_q;
    assign full_settling_trigger = mode_q[ire_pkg::MODE_TRIG_BIT];
    assign repetitive_retrigger = mode_q[ire_pkg::MODE_RETRIG_BIT];
    assign display_locked = mode_q[ire_pkg::MODE_LOCK_BIT];
    assign screen_sel = mode_q[ire_pkg::MODE_SCREEN_LSB +: ire_pkg::SCREEN_W];
    assign cfg_fields = cfg_q[15:0];
    assign print_title = title_q;
    assign reset_busy = busy;

endmodule

// file: sim/ire_props.sv
// concurrent checks on the ports of the reset-effects sequencer
// assumes binding to ire_top, one clock, rst synchronous and active high
`timescale 1ns/1ps
module ire_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_ack,
    input wire logic power_ok,
    input wire logic preset_key,
    input wire logic selftest_start,
    input wire logic abort_ops,
    input wire logic bus_if_reset,
    input wire logic srq,
    input wire logic full_settling_trigger,
    input wire logic repetitive_retrigger,
    input wire logic display_locked,
    input wire logic [3:0] screen_sel,
    input wire logic [15:0] cfg_fields,
    input wire logic [31:0] print_title,
    input wire logic reset_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // power-on reset
    a_por_effects: assert property ($rose(power_ok) |=> abort_ops && bus_if_reset && !srq)
        else $error("power-on reset missed abort, bus reset or request drop");
    a_por_busy_run: assert property ($rose(power_ok) |=> reset_busy [*8])
        else $error("power-on reset sequence not running");
    a_por_runs_test: assert property ($rose(power_ok) |-> ##[2:80] selftest_start)
        else $error("power-on reset never started self-test");
    a_test_in_por: assert property (selftest_start |-> reset_busy ##1 !selftest_start)
        else $error("self-test start outside power-on sequence");

    ////////////////////////////////////////////////////////////////////////////////
    // preset reset; a concurrent power edge takes precedence
    a_preset_quiet: assert property ($rose(preset_key) && !reset_busy && !$rose(power_ok)
        |=> (abort_ops && !bus_if_reset && !reset_busy) ##1 (!selftest_start) [*4])
        else $error("preset reset started self-test or bus reset");
    a_preset_srq_kept: assert property ($rose(preset_key) && !reset_busy && !$rose(power_ok)
        && srq |=> srq)
        else $error("preset reset dropped the service request");

    ////////////////////////////////////////////////////////////////////////////////
    // effects shared by both resets, visible with the abort pulse; then the single-cycle bus acknowledge
    a_reset_defaults: assert property (abort_ops |-> full_settling_trigger
        && repetitive_retrigger && !display_locked && screen_sel == 4'h1
        && print_title == 32'h0)
        else $error("mode, screen or title not at default after reset");
    a_cfg_restore: assert property (abort_ops |-> cfg_fields[11:0] == 12'h005
        && cfg_fields[15:12] == $past(cfg_fields[15:12]))
        else $error("configuration fields wrongly restored");
    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("bus acknowledge longer than one cycle");
endmodule

// file: sim/ire_selftest_model.sv
// behavioural self-test engine on the far side of the sequencer
// assumes selftest_start is a one-cycle pulse; delay sets how slowly it answers
`timescale 1ns/1ps
module ire_selftest_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic selftest_start,
    input wire logic [7:0] delay,
    output logic selftest_done,
    output logic selftest_pass
);
    logic [8:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 9'h000;
        end else if (selftest_start) begin
            cnt_q <= {1'b0, delay} + 9'h001;
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end
    end

    // result only qualified with done; low otherwise so a stale pass is not seen
    assign selftest_done = (cnt_q == 9'h001);
    assign selftest_pass = (cnt_q == 9'h001);
endmodule

// file: sim/testbench.sv
// self-checking bench for the reset-effects sequencer
// assumes ire_top, ire_props and ire_selftest_model compiled before it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ire_pkg::ire_wb_req_type wb_req = '0;
    logic power_ok = 1'b1;
    logic preset_key = 1'b0;
    logic op_done = 1'b0;
    logic [7:0] test_delay = 8'h03;
    logic wb_ack, selftest_start, selftest_done, selftest_pass, abort_ops, bus_if_reset, srq;
    logic full_settling_trigger, repetitive_retrigger, display_locked, reset_busy;
    logic [3:0] screen_sel;
    logic [15:0] cfg_fields;
    logic [31:0] wb_dat_o, print_title, rd;
    int n_mismatch = 0;
    int total_checks = 0;

    ire_top i_ire_top (.core_clk, .rst, .wb_req, .wb_ack, .wb_dat_o, .power_ok, .preset_key,
        .selftest_start, .selftest_done, .selftest_pass, .op_done, .abort_ops, .bus_if_reset,
        .srq, .full_settling_trigger, .repetitive_retrigger, .display_locked, .screen_sel,
        .cfg_fields, .print_title, .reset_busy);
    ire_selftest_model i_ire_selftest_model (.core_clk, .rst, .selftest_start,
        .delay(test_delay), .selftest_done, .selftest_pass);

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus and helper tasks; each is entered just after a rising edge
    task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 400);
        rd = wb_dat_o;
        if (n >= 400) begin
            n_mismatch++;
            $display("BAD wb_ack expected 1 seen 0");
        end
        wb_req <= '0;
        @(posedge core_clk);
    endtask

    task automatic rchk(input string nm, input logic [8:0] adr, input logic [31:0] e);
        wb(1'b0, adr, 32'h0);
        `CHK(nm, e, rd)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (reset_busy !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // mixes every bit class so both a cleared and a kept word are told apart
    task automatic fill();
        for (int i = 0; i < 23; i++) begin
            wb(1'b1, ire_pkg::OFS_MEM_BASE + 9'(4 * i), 32'h0000_5a00 | i);
        end
        wb(1'b1, ire_pkg::OFS_MODE, 32'h0000_0054);
        wb(1'b1, ire_pkg::OFS_CFG, 32'h0000_f123);
        wb(1'b1, ire_pkg::OFS_TITLE, 32'hdead_beef);
        wb(1'b1, ire_pkg::OFS_MENU, 32'h0bad_cafe);
        wb(1'b1, ire_pkg::OFS_SRQ, 32'h0000_0001);
        wb(1'b1, ire_pkg::OFS_OPC, 32'h0000_0007);
    endtask

    task automatic common_chk();
        rchk("mode", ire_pkg::OFS_MODE, 32'h0000_0013);
        rchk("cfg", ire_pkg::OFS_CFG, 32'h0000_f005);
        rchk("title", ire_pkg::OFS_TITLE, 32'h0);
        rchk("menu", ire_pkg::OFS_MENU, 32'h0bad_cafe);
        wb(1'b0, ire_pkg::OFS_OPC, 32'h0);
        `CHK("opc", 32'h0, rd & 32'h17)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_power_on();
        wait_idle();
        rchk("status", ire_pkg::OFS_STATUS, 32'h0000_0016);
        for (int i = 0; i < 23; i++) begin
            rchk("store", ire_pkg::OFS_MEM_BASE + 9'(4 * i), (i < 16) ? 32'h0 : 32'hffff);
        end
        wb(1'b1, 9'h020, 32'hffff_ffff);
        rchk("unmapped", 9'h020, 32'h0);
        $display("test power_on done");
    endtask

    task automatic t_preset();
        fill();
        preset_key <= 1'b1;
        repeat (3) @(posedge core_clk);
        preset_key <= 1'b0;
        @(posedge core_clk);
        rchk("status", ire_pkg::OFS_STATUS, 32'h0000_0008 | 32'h0000_0012);
        common_chk();
        rchk("srq", ire_pkg::OFS_SRQ, 32'h1);
        for (int i = 0; i < 23; i++) begin
            rchk("store", ire_pkg::OFS_MEM_BASE + 9'(4 * i), 32'h0000_5a00 | i);
        end
        op_done <= 1'b1;
        @(posedge core_clk);
        op_done <= 1'b0;
        @(posedge core_clk);
        rchk("opc_late", ire_pkg::OFS_OPC, 32'h0);
        wb(1'b1, ire_pkg::OFS_OPC, 32'h0000_0007);
        op_done <= 1'b1;
        @(posedge core_clk);
        op_done <= 1'b0;
        wb(1'b0, ire_pkg::OFS_OPC, 32'h0);
        `CHK("opc_armed", 32'h18, rd & 32'h1b)
        $display("test preset done");
    endtask

    task automatic t_power_cycle();
        test_delay <= 8'h28;
        fill();
        power_ok <= 1'b0;
        repeat (2) @(posedge core_clk);
        power_ok <= 1'b1;
        repeat (2) @(posedge core_clk);
        wait_idle();
        rchk("srq", ire_pkg::OFS_SRQ, 32'h0);
        common_chk();
        for (int i = 0; i < 23; i++) begin
            rchk("store", ire_pkg::OFS_MEM_BASE + 9'(4 * i), (i < 16) ? 32'h0 : 32'hffff);
        end
        $display("test power_cycle done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // sequence, verdict and watchdog
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_power_on();
        t_preset();
        t_power_cycle();
        conclude();
    end

    initial begin
        repeat (10000) @(posedge core_clk);
        n_mismatch++;
        conclude();
    end
endmodule

bind ire_top ire_props i_ire_props (.core_clk, .rst, .wb_ack, .power_ok, .preset_key,
    .selftest_start, .abort_ops, .bus_if_reset, .srq, .full_settling_trigger,
    .repetitive_retrigger, .display_locked, .screen_sel, .cfg_fields, .print_title,
    .reset_busy);
